// *** include/spi_ee_pkg.sv ***
/*
 * Shared constants for the serial EEPROM command and protect logic and
 * for its SPI controller: opcodes, status fields, timing and the
 * controller's own register map.
 * Assumes a 125 MHz system clock common to both ends.
 */
package spi_ee_pkg;

	// Opcodes; bit 3 is a don't-care, removed by the mask.
	localparam logic [7:0] OP_MASK  = 8'hF7;
	localparam logic [7:0] OP_SET_WE  = 8'h06;
	localparam logic [7:0] OP_CLR_WE  = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_WR_STAT = 8'h01;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;

	// Status register field positions.
	localparam int SR_BUSY = 0;
	localparam int SR_WEL  = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 3;
	localparam int SR_HPE  = 7;
	localparam logic [7:0] SR_BUSY_VIEW = 8'hFF;
	localparam logic [1:0] BP_RESET  = 2'h0;
	localparam logic       HPE_RESET = 1'b0;

	// Array geometry and protected region bases.
	localparam int ADDR_W = 12;
	localparam int PAGE_W = 5;
	localparam logic [11:0] PROT_QTR_BASE  = 12'hC00;
	localparam logic [11:0] PROT_HALF_BASE = 12'h800;

	// Timing.
	localparam int CLK_PERIOD_NS  = 8;
	localparam int WRITE_TIME_NS  = 5000000;
	localparam int WRITE_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int LINK_PERIOD_NS = 160;
	localparam int SCK_HALF_CYCLES = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;

	// Controller registers, byte addresses.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TX   = 8'h04;
	localparam logic [7:0] REG_RX   = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_DIV  = 8'h10;
	localparam int CTRL_CS   = 0;
	localparam int CTRL_WP_N = 1;
	localparam int STAT_RUN  = 0;
	localparam int STAT_CS_N = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// Device frame states, Gray along idle-op-addr-write.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OP   = 3'h1,
		ST_ADDR = 3'h3,
		ST_ARRW = 3'h2,
		ST_TX   = 3'h6,
		ST_WSR  = 3'h7
	} dev_state_e;

endpackage : spi_ee_pkg

// *** include/spi_link_if.sv ***
/*
 * The serial link between controller and EEPROM device.
 * Assumes the bench reads the output enable; the so_line net shows a
 * pulled-up level whenever the device is not driving.
 */
`timescale 1ns/1ps
interface spi_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic wp_n;
	logic so;
	logic so_oe_n;
	logic so_line;

	// Resolved data-out level; an undriven line floats high.
	assign so_line = so_oe_n ? 1'b1 : so;

	modport dev (
		input  cs_n,
		input  sck,
		input  si,
		input  wp_n,
		output so,
		output so_oe_n
	);

	modport ctl (
		output cs_n,
		output sck,
		output si,
		output wp_n,
		input  so_line
	);
endinterface : spi_link_if

// *** rtl/spi_ee_ctl.sv ***
/*
 * SPI mode 0 controller for the serial EEPROM, steered by software
 * through five APB registers: select, send byte, received byte, status
 * and clock divider.
 * Assumes zero-wait APB and that software sequences the opcode bytes.
 */
`timescale 1ns/1ps
module spi_ee_ctl #(
	parameter int HALF_CYCLES = spi_ee_pkg::SCK_HALF_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	spi_link_if.ctl          link,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	import spi_ee_pkg::*;

	logic [1:0] so_meta_q, so_sync_q;
	logic [1:0] ctrl_q, ctrl_d;
	logic [7:0] div_q, div_d, cnt_q, cnt_d, tx_q, tx_d, rx_q, rx_d;
	logic [2:0] bit_q, bit_d;
	logic       run_q, run_d, sck_q, sck_d, si_q, si_d;
	logic       cs_n_q, cs_n_d;
	logic       acc, wr, mapped;
	logic [7:0] reload;

	// Data-out from the device crosses in through four flops.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			so_meta_q <= 2'h3;
			so_sync_q <= 2'h3;
		end else begin
			so_meta_q <= {so_meta_q[0], link.so_line};
			so_sync_q <= {so_sync_q[0], so_meta_q[1]};
		end
	end

	// APB decode; every access completes in its first access cycle.
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_TX) ||
		(paddr == REG_RX) || (paddr == REG_STAT) || (paddr == REG_DIV);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign reload = (div_q < 8'h02) ? 8'h02 : div_q;

	// Read mux; unmapped addresses read zero.
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			REG_CTRL: prdata[1:0] = ctrl_q;
			REG_TX:   prdata[7:0] = tx_q;
			REG_RX:   prdata[7:0] = rx_q;
			REG_STAT: prdata[1:0] = {cs_n_q, run_q};
			REG_DIV:  prdata[7:0] = div_q;
			default:  prdata = 32'h0000_0000;
		endcase
	end

	// Byte engine and register writes.
	always_comb begin
		ctrl_d = ctrl_q;
		div_d = div_q;
		cnt_d = cnt_q;
		tx_d = tx_q;
		rx_d = rx_q;
		bit_d = bit_q;
		run_d = run_q;
		sck_d = sck_q;
		si_d = si_q;
		cs_n_d = cs_n_q;
		if (wr && paddr == REG_CTRL) begin
			ctrl_d = pwdata[1:0];
		end
		if (wr && paddr == REG_DIV) begin
			div_d = pwdata[7:0];
		end
		// Select only moves between bytes, so it never rises mid-bit.
		if (!run_q) begin
			cs_n_d = ~ctrl_q[CTRL_CS];
		end
		if (wr && paddr == REG_TX && !run_q && !cs_n_q) begin
			tx_d = pwdata[7:0];
			si_d = pwdata[7];
			run_d = 1'b1;
			bit_d = 3'h0;
			cnt_d = reload;
		end else if (run_q) begin
			cnt_d = cnt_q - 8'h01;
			if (cnt_q == 8'h01) begin
				cnt_d = reload;
				if (!sck_q) begin
					sck_d = 1'b1;
					rx_d = {rx_q[6:0], so_sync_q[1]};
				end else begin
					sck_d = 1'b0;
					tx_d = {tx_q[6:0], 1'b0};
					si_d = tx_q[6];
					bit_d = bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						run_d = 1'b0;
					end
				end
			end
		end
	end

	// Engine registers; the clock idles low for mode 0.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			div_q <= 8'(HALF_CYCLES);
			cnt_q <= 8'h00;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			bit_q <= 3'h0;
			run_q <= 1'b0;
			sck_q <= 1'b0;
			si_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			div_q <= div_d;
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			bit_q <= bit_d;
			run_q <= run_d;
			sck_q <= sck_d;
			si_q <= si_d;
			cs_n_q <= cs_n_d;
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sck = sck_q;
	assign link.si = si_q;
	assign link.wp_n = ctrl_q[CTRL_WP_N];

endmodule : spi_ee_ctl

// *** rtl/spi_ee_device.sv ***
/*
 * Command decoder, status register and write protection of a serial
 * EEPROM, seen from its SPI slave pins.
 * Assumes all link pins are asynchronous to clk and that the link clock
 * half period spans at least four clk cycles. The array itself sits
 * outside: accepted write bytes leave on wr_*, read data enter on
 * rd_data for the address on rd_addr.
 */
`timescale 1ns/1ps

// Overview of operation
// - Status register writable only when unprotected.
// - Bit 0 busy; busy accepts only status read.
// - Latch cleared at reset, set by enable.
// - Block bits reset zero, always guard array.
// - Bits four to six read zero.
// - Enable bit plus low pin locks status.
// - Enable bit clears only with pin high.
// - All status bits read one while busy.
// - Block pair selects quarter, half or all.
// - Opcode then address, data, MSB first.
// - Output bits change on falling clock edge.
// - Chip select rise ends frame, starts operation.
// - Decode latch set, clear and status read.
// - Decode status write, array read, write.
// - Opcode bit three is ignored.
// - Latch cleared after clear, status, array write.
// - Status byte repeats while select stays low.
// - Status write keeps only protect bits.
// - Status write needs latch, no hardware lock.
// - New status settings apply after cycle.
// - Controller reads status before any write.
// - Only SPI modes zero and three.
// - Standby with output released when deselected.
module spi_ee_device #(
	parameter int WRITE_CYCLES = spi_ee_pkg::WRITE_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	spi_link_if.dev                            link,
	output logic                               wr_stb,
	output logic [spi_ee_pkg::ADDR_W-1:0]      wr_addr,
	output logic [7:0]                         wr_data,
	output logic [spi_ee_pkg::ADDR_W-1:0]      rd_addr,
	input  wire logic [7:0]                    rd_data,
	output logic                               busy
);
	import spi_ee_pkg::*;

	localparam int CW = $clog2(WRITE_CYCLES + 1);

	logic [3:0]          meta_q, sync_q, prev_q;
	logic                sck_s, cs_s, si_s, wp_s;
	logic                sck_rise, sck_fall, cs_rise, cs_fall;
	dev_state_e          st_q, st_d;
	logic [2:0]          bit_q, bit_d;
	logic [7:0]          op_q, op_d, sh_q, sh_d, tx_q, tx_d;
	logic [ADDR_W-1:0]   addr_q, addr_d;
	logic                abyte_q, abyte_d, opok_q, opok_d;
	logic                so_q, so_d, oe_n_q, oe_n_d;
	logic                wel_q, wel_d, hpe_q, hpe_d;
	logic [1:0]          bp_q, bp_d;
	logic [2:0]          pend_q, pend_d;
	logic                pendv_q, pendv_d, wsr_q, wsr_d;
	logic                busy_q, busy_d, wany_q, wany_d;
	logic [CW-1:0]       wcnt_q, wcnt_d;
	logic                stb_q, stb_d;
	logic [ADDR_W-1:0]   waddr_q, waddr_d;
	logic [7:0]          wdat_q, wdat_d;
	logic [7:0]          nb, cmd, view, obyte;
	logic                hwp, new_hpe;

	// Two flops per pin, then one more stage used only for edges.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 4'hF;
			sync_q <= 4'hF;
			prev_q <= 4'hF;
		end else begin
			meta_q <= {link.wp_n, link.si, link.cs_n, link.sck};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edge events; the link clock is only trusted while selected.
	assign sck_s    = sync_q[0];
	assign cs_s     = sync_q[1];
	assign si_s     = sync_q[2];
	assign wp_s     = sync_q[3];
	assign sck_rise = sck_s & ~prev_q[0] & ~cs_s;
	assign sck_fall = ~sck_s & prev_q[0] & ~cs_s;
	assign cs_rise  = cs_s & ~prev_q[1];
	assign cs_fall  = ~cs_s & prev_q[1];

	// Array protect test for the current block pair.
	function automatic logic prot(input logic [1:0] bp,
			input logic [ADDR_W-1:0] a);
		unique case (bp)
			2'h0: prot = 1'b0;
			2'h1: prot = (a >= PROT_QTR_BASE);
			2'h2: prot = (a >= PROT_HALF_BASE);
			2'h3: prot = 1'b1;
		endcase
	endfunction : prot

	// Hardware lock and the byte that a status read shows.
	assign hwp  = hpe_q & ~wp_s;
	assign view = busy_q ? SR_BUSY_VIEW :
		{hpe_q, 3'h0, bp_q, wel_q, 1'b0};
	assign nb   = {sh_q[6:0], si_s};
	assign cmd  = op_q & OP_MASK;
	assign obyte = (cmd == OP_RD_STAT) ? view : rd_data;
	// Refusing to drop the enable bit is kept even though the lock
	// already blocks the write; both read the same wp_s sample.
	assign new_hpe = nb[7] | (hpe_q & ~wp_s);

	// Next-state logic for the frame decoder and the status bits.
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		op_d = op_q;
		sh_d = sh_q;
		tx_d = tx_q;
		addr_d = addr_q;
		abyte_d = abyte_q;
		opok_d = opok_q;
		so_d = so_q;
		oe_n_d = oe_n_q;
		wel_d = wel_q;
		hpe_d = hpe_q;
		bp_d = bp_q;
		pend_d = pend_q;
		pendv_d = pendv_q;
		wsr_d = wsr_q;
		busy_d = busy_q;
		wany_d = wany_q;
		wcnt_d = wcnt_q;
		stb_d = 1'b0;
		waddr_d = waddr_q;
		wdat_d = wdat_q;
		// Self-timed cycle; status settings land only at its end.
		if (busy_q) begin
			wcnt_d = wcnt_q - 1'b1;
			if (wcnt_q == CW'(1)) begin
				busy_d = 1'b0;
				pendv_d = 1'b0;
				if (pendv_q) begin
					hpe_d = pend_q[2];
					bp_d = pend_q[1:0];
				end
			end
		end
		if (cs_fall) begin
			st_d = ST_OP;
			bit_d = 3'h0;
			abyte_d = 1'b0;
			opok_d = 1'b0;
			wany_d = 1'b0;
			wsr_d = 1'b0;
		end else if (cs_rise) begin
			st_d = ST_IDLE;
			oe_n_d = 1'b1;
			// The operation starts on deselect, never earlier.
			if (opok_q && !busy_q) begin
				unique case (cmd)
					OP_SET_WE: wel_d = 1'b1;
					OP_CLR_WE: wel_d = 1'b0;
					OP_WR_STAT: if (wsr_q) begin
						wel_d = 1'b0;
						pendv_d = 1'b1;
						busy_d = 1'b1;
						wcnt_d = CW'(WRITE_CYCLES);
					end
					OP_WRITE: if (wany_q) begin
						wel_d = 1'b0;
						busy_d = 1'b1;
						wcnt_d = CW'(WRITE_CYCLES);
					end
					default: ;
				endcase
			end
		end else if (sck_rise) begin
			sh_d = nb;
			bit_d = bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				unique case (st_q)
					ST_OP: begin
						op_d = nb;
						opok_d = !busy_q ||
							((nb & OP_MASK) == OP_RD_STAT);
						st_d = ST_IDLE;
						if (opok_d) begin
							unique case (nb & OP_MASK)
								OP_RD_STAT: st_d = ST_TX;
								OP_READ, OP_WRITE: st_d = ST_ADDR;
								OP_WR_STAT: st_d = ST_WSR;
								default: st_d = ST_IDLE;
							endcase
						end
					end
					ST_ADDR: begin
						abyte_d = 1'b1;
						if (!abyte_q) begin
							addr_d[11:8] = nb[3:0];
						end else begin
							addr_d[7:0] = nb;
							st_d = (cmd == OP_READ) ? ST_TX : ST_ARRW;
						end
					end
					ST_WSR: begin
						pend_d = {new_hpe, nb[SR_BP_HI],
							nb[SR_BP_LO]};
						wsr_d = wel_q & ~hwp;
						st_d = ST_IDLE;
					end
					ST_ARRW: begin
						if (wel_q && !prot(bp_q, addr_q)) begin
							stb_d = 1'b1;
							waddr_d = addr_q;
							wdat_d = nb;
							wany_d = 1'b1;
						end
						// Writes wrap inside the current page.
						addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] +
							PAGE_W'(1);
					end
					default: ;
				endcase
			end
		end else if (sck_fall && st_q == ST_TX) begin
			oe_n_d = 1'b0;
			// A fresh byte is fetched once every eight bits.
			if (bit_q == 3'h0) begin
				so_d = obyte[7];
				tx_d = {obyte[6:0], 1'b0};
				if (cmd == OP_READ) begin
					addr_d = addr_q + 12'h001;
				end
			end else begin
				so_d = tx_q[7];
				tx_d = {tx_q[6:0], 1'b0};
			end
		end
	end

	// State registers; protect bits come up at their factory value.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			bit_q <= 3'h0;
			op_q <= 8'h00;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			addr_q <= 12'h000;
			abyte_q <= 1'b0;
			opok_q <= 1'b0;
			so_q <= 1'b0;
			oe_n_q <= 1'b1;
			wel_q <= 1'b0;
			hpe_q <= HPE_RESET;
			bp_q <= BP_RESET;
			pend_q <= 3'h0;
			pendv_q <= 1'b0;
			wsr_q <= 1'b0;
			busy_q <= 1'b0;
			wany_q <= 1'b0;
			wcnt_q <= '0;
			stb_q <= 1'b0;
			waddr_q <= 12'h000;
			wdat_q <= 8'h00;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			op_q <= op_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			addr_q <= addr_d;
			abyte_q <= abyte_d;
			opok_q <= opok_d;
			so_q <= so_d;
			oe_n_q <= oe_n_d;
			wel_q <= wel_d;
			hpe_q <= hpe_d;
			bp_q <= bp_d;
			pend_q <= pend_d;
			pendv_q <= pendv_d;
			wsr_q <= wsr_d;
			busy_q <= busy_d;
			wany_q <= wany_d;
			wcnt_q <= wcnt_d;
			stb_q <= stb_d;
			waddr_q <= waddr_d;
			wdat_q <= wdat_d;
		end
	end

	// Outputs, all from flops.
	assign link.so = so_q;
	assign link.so_oe_n = oe_n_q;
	assign wr_stb = stb_q;
	assign wr_addr = waddr_q;
	assign wr_data = wdat_q;
	assign rd_addr = addr_q;
	assign busy = busy_q;

endmodule : spi_ee_device

// *** tb/spi_eeprom_cmd_status_protect_tb.sv ***
/*
 * Bench: controller and device joined by the link, orders sent over APB.
 * Assumes the package and interface compile first; a small array model
 * answers reads and records accepted write bytes.
 */
`timescale 1ns/1ps
module spi_eeprom_cmd_status_protect_tb;
	import spi_ee_pkg::*;
	// Long cycle so that status can be read while it runs.
	localparam int WCYC = 1000;
	localparam logic [11:0] ADR [4] = '{12'h7FF, 12'h800, 12'hBFF, 12'hC00};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        err_q;
	logic        wr_stb;
	logic        busy;
	logic        wp = 1'b1;
	logic [11:0] wr_addr;
	logic [11:0] rd_addr;
	logic [11:0] got_a;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic [7:0]  got_d;
	int          n_stb = 0;
	int          error_cnt = 0;
	int          checks_done = 0;

	always #4 clk = ~clk;

	spi_link_if spi_link_if_inst ();
	spi_ee_device #(.WRITE_CYCLES(WCYC)) spi_ee_device_inst (
		.clk(clk), .rst(rst), .link(spi_link_if_inst.dev),
		.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
	spi_ee_ctl spi_ee_ctl_inst (
		.clk(clk), .rst(rst), .link(spi_link_if_inst.ctl),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	spi_link_checker spi_link_checker_inst (
		.clk(clk), .rst(rst), .cs_n(spi_link_if_inst.cs_n),
		.sck(spi_link_if_inst.sck), .si(spi_link_if_inst.si),
		.so(spi_link_if_inst.so), .so_oe_n(spi_link_if_inst.so_oe_n));

	// Array model: read data is a pattern of the address.
	assign rd_data = rd_addr[7:0] ^ 8'h5A;
	always @(posedge clk) begin
		if (wr_stb === 1'b1) begin
			got_a <= wr_addr;
			got_d <= wr_data;
			n_stb <= n_stb + 1;
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	// One APB transfer; entered just after a rising edge.
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d, output logic [31:0] r);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic sel(input logic on);
		logic [31:0] r;
		apb(REG_CTRL, 1'b1, {30'h0, wp, on}, r);
	endtask : sel

	// Send a byte and wait for the exchange to finish.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		logic [31:0] r;
		int n;
		n = 0;
		apb(REG_TX, 1'b1, {24'h0, tx}, r);
		do begin
			apb(REG_STAT, 1'b0, 32'h0, r);
			n++;
		end while (r[STAT_RUN] && n < 100);
		// A byte that never finishes is a failure, not a silent skip.
		if (r[STAT_RUN]) begin
			error_cnt++;
			summarize();
		end
		apb(REG_RX, 1'b0, 32'h0, r);
		rx = r[7:0];
	endtask : xfer

	task automatic frame(input logic [31:0] b, input int nb,
			output logic [7:0] rx);
		sel(1'b1);
		for (int i = 0; i < nb; i++) begin
			xfer(b[31-8*i -: 8], rx);
		end
		sel(1'b0);
	endtask : frame

	task automatic read_status(output logic [7:0] s);
		logic [7:0] t;
		sel(1'b1);
		xfer(OP_RD_STAT, t);
		xfer(8'h00, s);
		xfer(8'h00, t);
		sel(1'b0);
		cmp(32'(t), 32'(s));
	endtask : read_status

	// Busy rises a few cycles after select is released.
	task automatic wait_ready();
		int n;
		n = 0;
		repeat (6) @(posedge clk);
		while (busy !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		// A write cycle that never ends is counted and closes the run.
		if (busy !== 1'b0) begin
			error_cnt++;
			summarize();
		end
	endtask : wait_ready

	initial begin
		logic [7:0]  s;
		logic [31:0] r;
		logic [11:0] a;
		logic        p;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		apb(REG_CTRL, 1'b0, 32'h0, r);
		cmp(r, 32'h2);
		apb(8'h20, 1'b0, 32'h0, r);
		cmp({r[30:0], err_q}, 32'h1);
		read_status(s);
		cmp(32'(s), 32'h00);
		frame({8'h0E, 24'h0}, 1, s);
		read_status(s);
		cmp(32'(s), 32'h02);
		frame({8'h0C, 24'h0}, 1, s);
		read_status(s);
		cmp(32'(s), 32'h00);
		frame({OP_WR_STAT, 8'hFF, 16'h0}, 2, s);
		wait_ready();
		read_status(s);
		cmp(32'(s), 32'h00);
		frame({OP_SET_WE, 24'h0}, 1, s);
		frame({OP_WR_STAT, 8'hFC, 16'h0}, 2, s);
		read_status(s);
		cmp(32'(s), 32'hFF);
		cmp(32'(busy), 32'h1);
		frame({OP_SET_WE, 24'h0}, 1, s);
		wait_ready();
		read_status(s);
		cmp(32'(s), 32'h8C);
		// Pin low with the enable bit set locks the status register.
		wp = 1'b0;
		frame({OP_SET_WE, 24'h0}, 1, s);
		frame({OP_WR_STAT, 8'h00, 16'h0}, 2, s);
		wait_ready();
		read_status(s);
		cmp(32'(s), 32'h8E);
		wp = 1'b1;
		frame({OP_WR_STAT, 8'h00, 16'h0}, 2, s);
		wait_ready();
		read_status(s);
		cmp(32'(s), 32'h00);
		// Each block level against addresses either side of its bases.
		for (int b = 0; b < 4; b++) begin
			frame({OP_SET_WE, 24'h0}, 1, s);
			frame({OP_WR_STAT, 4'h0, 2'(b), 2'h0, 16'h0}, 2, s);
			wait_ready();
			for (int k = 0; k < 4; k++) begin
				a = ADR[k];
				p = b == 3 || (b == 2 && a >= PROT_HALF_BASE) ||
					(b == 1 && a >= PROT_QTR_BASE);
				r = 32'(n_stb);
				frame({OP_SET_WE, 24'h0}, 1, s);
				// Latch set and device ready before the array write.
				read_status(s);
				cmp(32'(s), {28'h0, 2'(b), 2'h2});
				frame({OP_WRITE, 4'hF, a, a[7:0] ^ 8'h3C}, 4, s);
				wait_ready();
				cmp(32'(n_stb) - r, p ? 32'h0 : 32'h1);
				if (!p) begin
					cmp({got_a, got_d}, {12'h0, a, a[7:0] ^ 8'h3C});
				end
				read_status(s);
				cmp(32'(s), {28'h0, 2'(b), p, 1'b0});
			end
		end
		// Read across the top of the array: the address wraps to zero.
		sel(1'b1);
		xfer(OP_READ, s);
		xfer(8'hFF, s);
		xfer(8'hFF, s);
		xfer(8'h00, s);
		cmp(32'(s), 32'hA5);
		xfer(8'h00, s);
		cmp(32'(s), 32'h5A);
		sel(1'b0);
		summarize();
	end

	// A hang ends the run through the same verdict.
	initial begin
		#800000;
		error_cnt++;
		summarize();
	end
endmodule : spi_eeprom_cmd_status_protect_tb

// *** tb/spi_link_assertions.sv ***
/*
 * Checker for the serial link between the controller and the device.
 * Assumes one clk domain, a link clock that idles low (mode 0) and
 * an active high rst.
 */
`timescale 1ns/1ps
module spi_link_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// The device releases its output soon after it is deselected.
	a_so_released: assert property (cs_n [*6] |-> so_oe_n)
		else $error("data out still driven while deselected");
	// The link clock rests low outside frames.
	a_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("link clock high while deselected");
	// The device samples on the rise, so data in holds while sck is high.
	a_si_held_high: assert property (sck |-> $stable(si))
		else $error("data in moved while link clock high");
	// Data out moves only in the low phase, after the falling edge.
	a_so_moves_low: assert property
		(!so_oe_n && $changed(so) |-> !sck)
		else $error("data out changed while link clock high");
	a_so_first_drive: assert property
		($fell(so_oe_n) |-> !cs_n && !sck)
		else $error("data out enabled outside a low phase");
	// Chip select moves only with the link clock low on both sides.
	a_cs_moves_low: assert property
		($changed(cs_n) |-> !sck && !$past(sck))
		else $error("chip select moved near a link clock edge");
	a_sck_high_phase: assert property ($rose(sck) |-> sck [*8])
		else $error("link clock high phase too short");
	a_cs_lead_time: assert property ($fell(cs_n) |-> !sck [*8])
		else $error("first rise too soon after select");
endmodule : spi_link_checker
